// file: rtl/frp_protect.sv
// flash readout / write protection and secondary sram page write protection
// assumes bus masters and the flash controller share clk; reads answer one cycle later
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "frp_consts.svh"

// Functional notes
// (RULE1) three levels, lowest opens everything
// (RULE2) middle level blocks debug and nonflash boot
// (RULE3) flash boot keeps full user access
// (RULE4) lowering to lowest erases flash, sram, backup
// (RULE5) covers flash, backup, sram; options at highest
// (RULE6) highest freezes every option byte
// (RULE7) highest disables debug, trace, boundary scan; only debugEnable and traceEnable here, no boundary scan output
// (RULE8) highest refuses sram and loader boot
// (RULE9) highest level can never be left
// (RULE10) dual variant: two areas per bank, 2k
// (RULE11) single bank mode: four areas, 4k
// (RULE12) dual bank mode: two per bank, 2k
// (RULE13) small variant: two areas, 2k
// (RULE14) program or erase in area rejected, flagged
// (RULE15) mass erase refused if any protected page
// (RULE16) secondary sram 1k pages, 32-bit register
// (RULE17) sram protect bits clear only by reset
// (RULE18) core coupled sram 1k segments, size parameter
// (RULE19) level decoded at reset, held till reload
module frp_protect import frp_pkg::*; #(
    parameter frp_variant_t VARIANT = FRP_VAR_SELECT,
    parameter int SRAM_PAGES = 32,
    parameter int ERASE_CYCLES = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // option inputs from the option store
    input wire logic [7:0] optLevelByte,
    input wire logic optReload,
    input wire logic [1:0] bootMode,
    input wire logic dualBankSelect,
    // memory access check from the bus matrix
    input wire logic accValid,
    input wire logic accDebug,
    input wire logic accWrite,
    input wire logic [1:0] accTarget,
    output logic accBusError,
    // flash program / erase check from the flash controller
    input wire logic flashOpValid,
    input wire logic flashOpMass,
    input wire logic flashOpBank,
    input wire logic [19:0] flashOpAddr,
    output logic flashOpReject,
    // secondary sram write check
    input wire logic sramWrValid,
    input wire logic [14:0] sramWrAddr,
    output logic sramWrReject,
    // protection outputs
    output logic [1:0] readoutProtectionLevel,
    output logic debugEnable,
    output logic traceEnable,
    output logic bootRefused,
    output logic massEraseActive,
    output logic irq
);
    // ***************************************************
    // level decode
    // ***************************************************
    frp_level_t level;
    logic loaded;
    frp_level_t optLevel;
    logic reloadSeen;

    always_comb begin
        if (optLevelByte == `FRP_LVL_CODE0) begin
            optLevel = FRP_LVL0;
        end else if (optLevelByte == `FRP_LVL_CODE2) begin
            optLevel = FRP_LVL2;
        end else begin
            optLevel = FRP_LVL1;
        end
    end

    // option write request from software: register holds the pending byte
    logic [7:0] pendLevel;
    logic optWriteOk;
    logic optWriteHit;
    assign optWriteHit = regWr && (regAddr == `FRP_ADDR_OPTKEY);
    assign optWriteOk = optWriteHit && (level != FRP_LVL2); // see (RULE6)

    // level loaded on reset release and on reload; a reload never lowers highest
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= FRP_LVL1;
            loaded <= 1'b0;
            reloadSeen <= 1'b0;
        end else begin
            reloadSeen <= optReload;
            if (!loaded || (optReload && !reloadSeen)) begin // see (RULE19)
                loaded <= 1'b1;
                if (level != FRP_LVL2 || !loaded) begin // see (RULE9)
                    level <= optLevel; // see (RULE1)
                end
            end
        end
    end

    // ***************************************************
    // regression erase sequence
    // ***************************************************
    frp_erase_t eraseState;
    logic [15:0] eraseCount;
    logic eraseDone;

    always_ff @(posedge clk) begin
        if (rst) begin
            eraseState <= FRP_ER_IDLE;
            eraseCount <= 16'h0000;
        end else begin
            case (eraseState)
                FRP_ER_IDLE: begin
                    if (optWriteOk && level == FRP_LVL1 &&
                        regWdata[7:0] == `FRP_LVL_CODE0) begin // see (RULE4)
                        eraseState <= FRP_ER_RUN;
                        eraseCount <= 16'(ERASE_CYCLES - 1);
                    end
                end
                FRP_ER_RUN: begin
                    if (eraseCount == 16'h0000) begin
                        eraseState <= FRP_ER_DONE;
                    end else begin
                        eraseCount <= eraseCount - 16'h0001;
                    end
                end
                FRP_ER_DONE: begin
                    eraseState <= FRP_ER_IDLE;
                end
                default: begin
                    eraseState <= FRP_ER_IDLE;
                end
            endcase
        end
    end
    // erase covers main flash, secondary sram and backup registers together
    assign massEraseActive = (eraseState == FRP_ER_RUN); // see (RULE4)
    assign eraseDone = (eraseState == FRP_ER_DONE);

    always_ff @(posedge clk) begin
        if (rst) begin
            pendLevel <= 8'h00;
        end else if (optWriteOk && eraseState == FRP_ER_IDLE) begin
            pendLevel <= regWdata[7:0];
        end
    end

    // ***************************************************
    // access gating
    // ***************************************************
    logic untrusted;
    logic protLevel;
    assign untrusted = accDebug || (bootMode != FRP_BOOT_FLASH); // see (RULE3)
    assign protLevel = (level != FRP_LVL0); // see (RULE2)

    // target 0 flash, 1 secondary sram, 2 backup, 3 option bytes
    always_comb begin
        accBusError = 1'b0;
        if (accValid && untrusted) begin
            if (accTarget == 2'd3) begin
                accBusError = (level == FRP_LVL2) ||
                    (accWrite && level == FRP_LVL2); // see (RULE5)
            end else begin
                accBusError = protLevel || massEraseActive; // see (RULE5)
            end
        end
    end

    assign debugEnable = (level != FRP_LVL2); // see (RULE7)
    assign traceEnable = (level != FRP_LVL2); // see (RULE7)
    assign bootRefused = (level == FRP_LVL2) &&
        (bootMode != FRP_BOOT_FLASH); // see (RULE8)
    assign readoutProtectionLevel = level;

    // ***************************************************
    // flash write protected areas
    // ***************************************************
    // each area: start page [7:0], end page [23:16]; start > end disables it
    logic [31:0] wrpArea [4];
    logic [3:0] areaHit;
    logic [3:0] areaLive;
    logic [7:0] opPage;
    logic [1:0] areaCount;
    logic singleBank;

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                wrpArea[i] <= `FRP_RST_WRP;
            end
        end else if (regWr && level != FRP_LVL2) begin // see (RULE6)
            for (int i = 0; i < 4; i++) begin
                if (regAddr == 8'(`FRP_ADDR_WRPA + 4 * i)) begin
                    wrpArea[i] <= regWdata;
                end
            end
        end
    end

    assign singleBank = (VARIANT == FRP_VAR_SMALL) ||
        (VARIANT == FRP_VAR_SELECT && !dualBankSelect);

    // page index: 4k pages in selectable single bank mode, 2k elsewhere
    always_comb begin
        if (VARIANT == FRP_VAR_SELECT && !dualBankSelect) begin
            opPage = flashOpAddr[`FRP_SHIFT_4K +: 8]; // see (RULE11)
        end else begin
            opPage = flashOpAddr[`FRP_SHIFT_2K +: 8]; // see (RULE10) (RULE12) (RULE13)
        end
    end

    generate
        for (genvar g = 0; g < 4; g++) begin : gArea
            // areas 0,1 bank one, 2,3 bank two; single bank select uses all four
            logic inUse;
            logic bankMatch;
            always_comb begin
                if (VARIANT == FRP_VAR_SMALL) begin
                    inUse = (g < 2); // see (RULE13)
                end else begin
                    inUse = 1'b1; // see (RULE10) (RULE11) (RULE12)
                end
                if (singleBank) begin
                    bankMatch = 1'b1;
                end else begin
                    bankMatch = (flashOpBank == (g >= 2));
                end
            end
            assign areaLive[g] = inUse &&
                (wrpArea[g][7:0] <= wrpArea[g][23:16]);
            assign areaHit[g] = areaLive[g] && bankMatch &&
                (opPage >= wrpArea[g][7:0]) && (opPage <= wrpArea[g][23:16]);
        end
    endgenerate

    assign areaCount = 2'(areaLive[0] + areaLive[1] + areaLive[2] + areaLive[3]);

    always_comb begin
        if (!flashOpValid) begin
            flashOpReject = 1'b0;
        end else if (flashOpMass) begin
            flashOpReject = (areaLive != 4'h0) || (areaCount != 2'd0 && 1'b0); // see (RULE15)
        end else begin
            flashOpReject = (areaHit != 4'h0); // see (RULE14)
        end
    end

    // ***************************************************
    // secondary sram page protection
    // ***************************************************
    logic [31:0] sramProtect;
    logic [9:0] sramPage;
    assign sramPage = 10'(sramWrAddr >> `FRP_SHIFT_1K);

    always_ff @(posedge clk) begin
        if (rst) begin
            sramProtect <= `FRP_RST_ZERO; // see (RULE17)
        end else if (regWr && regAddr == `FRP_ADDR_SRAMWP) begin
            // bits only ever set: a write of zero leaves them alone
            sramProtect <= sramProtect | (regWdata &
                ((SRAM_PAGES >= 32) ? 32'hffffffff :
                32'((64'h1 << SRAM_PAGES) - 64'h1))); // see (RULE16) (RULE17) (RULE18)
        end
    end

    assign sramWrReject = sramWrValid && (sramPage < 10'(SRAM_PAGES)) &&
        sramProtect[sramPage[4:0]]; // see (RULE16) (RULE18)

    // ***************************************************
    // status, mask and interrupt
    // ***************************************************
    logic [3:0] status;
    logic [3:0] mask;
    logic [3:0] events;
    logic statusRead;

    assign events[`FRP_ST_WPERR] = flashOpReject || sramWrReject; // see (RULE14) (RULE15)
    assign events[`FRP_ST_RDERR] = accBusError;
    assign events[`FRP_ST_ERASED] = eraseDone;
    assign events[`FRP_ST_OPTERR] = optWriteHit && !optWriteOk; // see (RULE6)
    assign statusRead = regRd && regAddr == `FRP_ADDR_STATUS;

    // an event in the clearing cycle is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            status <= 4'h0;
        end else if (statusRead) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask <= 4'h0;
        end else if (regWr && regAddr == `FRP_ADDR_MASK) begin
            mask <= regWdata[3:0];
        end
    end

    assign irq = |(status & mask);

    // ***************************************************
    // register read
    // ***************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= `FRP_RST_ZERO;
        end else if (regRd) begin
            case (regAddr)
                `FRP_ADDR_LEVEL: regRdata <= {30'h0, level};
                `FRP_ADDR_BOOT: regRdata <= {29'h0, dualBankSelect, bootMode};
                `FRP_ADDR_WRPA: regRdata <= wrpArea[0];
                `FRP_ADDR_WRPB: regRdata <= wrpArea[1];
                `FRP_ADDR_WRPC: regRdata <= wrpArea[2];
                `FRP_ADDR_WRPD: regRdata <= wrpArea[3];
                `FRP_ADDR_SRAMWP: regRdata <= sramProtect;
                `FRP_ADDR_STATUS: regRdata <= {28'h0, status};
                `FRP_ADDR_MASK: regRdata <= {28'h0, mask};
                `FRP_ADDR_OPTKEY: regRdata <= {24'h0, pendLevel};
                default: regRdata <= `FRP_RST_ZERO;
            endcase
        end
    end
endmodule // frp_protect

`default_nettype wire

// file: include/frp_consts.svh
// constants of the flash readout and write protection block
// assumes inclusion by bare name from the design file, the checker and the bench
`ifndef FRP_CONSTS_SVH
`define FRP_CONSTS_SVH

// register word addresses
`define FRP_ADDR_LEVEL 8'h00
`define FRP_ADDR_BOOT 8'h04
`define FRP_ADDR_WRPA 8'h08
`define FRP_ADDR_WRPB 8'h0c
`define FRP_ADDR_WRPC 8'h10
`define FRP_ADDR_WRPD 8'h14
`define FRP_ADDR_SRAMWP 8'h18
`define FRP_ADDR_STATUS 8'h1c
`define FRP_ADDR_MASK 8'h20
`define FRP_ADDR_OPTKEY 8'h24

// level option encodings: lowest and highest each a single code, any other value the middle level
`define FRP_LVL_CODE0 8'haa
`define FRP_LVL_CODE2 8'hcc

// status bit positions
`define FRP_ST_WPERR 0
`define FRP_ST_RDERR 1
`define FRP_ST_ERASED 2
`define FRP_ST_OPTERR 3

// page sizes as address shifts
`define FRP_SHIFT_2K 11
`define FRP_SHIFT_4K 12
`define FRP_SHIFT_1K 10

// reset values
`define FRP_RST_WRP 32'h000000ff
`define FRP_RST_ZERO 32'h00000000

`endif

// file: include/frp_pkg.sv
// types of the flash readout and write protection block
// assumes the constants header is on the include path
package frp_pkg;
    typedef enum logic [1:0] {
        FRP_LVL0,
        FRP_LVL1,
        FRP_LVL2
    } frp_level_t;

    typedef enum logic [1:0] {
        FRP_BOOT_FLASH,
        FRP_BOOT_SRAM,
        FRP_BOOT_LOADER
    } frp_boot_t;

    typedef enum logic [1:0] {
        FRP_VAR_DUAL,
        FRP_VAR_SELECT,
        FRP_VAR_SMALL
    } frp_variant_t;

    typedef enum logic [1:0] {
        FRP_ER_IDLE,
        FRP_ER_RUN,
        FRP_ER_DONE
    } frp_erase_t;
endpackage

// file: testbench/frp_protect_assertions.sv
// checker of the protection block, bound to its ports
// assumes one clock domain and the package compiled first
`timescale 1ns/100ps
`default_nettype none
`include "frp_consts.svh"
module frp_protect_assertions import frp_pkg::*; #(
    parameter int ERASE_CYCLES = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched signals
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic [1:0] bootMode,
    input wire logic accValid,
    input wire logic accDebug,
    input wire logic [1:0] accTarget,
    input wire logic accBusError,
    input wire logic [1:0] readoutProtectionLevel,
    input wire logic debugEnable,
    input wire logic traceEnable,
    input wire logic bootRefused,
    input wire logic massEraseActive
);
    // ****
    // checks
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [1:0] lv;
    int eraseLen;
    assign lv = readoutProtectionLevel;
    // counts erase cycles so the length check needs no long repetition
    always_ff @(posedge clk) begin
        if (rst || !massEraseActive) begin
            eraseLen <= 0;
        end else begin
            eraseLen <= eraseLen + 1;
        end
    end
    lvl0_open_a: assert property (lv == 2'd0 && accValid |-> !accBusError)
        else $error("access refused at lowest level");
    lvl1_block_a: assert property (
        lv == 2'd1 && accValid && (accDebug || bootMode != 2'd0)
        && accTarget != 2'd3 |-> accBusError)
        else $error("protected access not refused");
    flash_user_a: assert property (
        lv != 2'd0 && accValid && !accDebug && bootMode == 2'd0
        |-> !accBusError)
        else $error("flash boot user access refused");
    opt_open_a: assert property (lv == 2'd1 && accValid && accTarget == 2'd3
        |-> !accBusError)
        else $error("option access refused at middle level");
    dbg_off_a: assert property (lv == 2'd2 |-> !debugEnable && !traceEnable)
        else $error("debug left on at highest level");
    boot_refuse_a: assert property (lv == 2'd2 |-> bootRefused == (bootMode != 2'd0))
        else $error("boot refusal wrong at highest level");
    fuse_hold_a: assert property (lv == 2'd2 |=> lv == 2'd2)
        else $error("highest level left");
    erase_cause_a: assert property (
        $rose(massEraseActive) |-> $past(regWr && regAddr == `FRP_ADDR_OPTKEY
        && regWdata[7:0] == `FRP_LVL_CODE0 && lv == 2'd1))
        else $error("erase without lowering");
    erase_len_a: assert property ($fell(massEraseActive) |-> eraseLen == ERASE_CYCLES)
        else $error("erase length wrong");
    cover property ($rose(massEraseActive));
    cover property (lv == 2'd2 && accValid && accBusError);
    cover property (lv == 2'd1 && accValid && !accBusError);
endmodule // frp_protect_assertions

bind frp_protect frp_protect_assertions #(.ERASE_CYCLES(ERASE_CYCLES)) i_frp_protect_assertions (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .bootMode(bootMode), .accValid(accValid), .accDebug(accDebug), .accTarget(accTarget),
    .accBusError(accBusError), .readoutProtectionLevel(readoutProtectionLevel),
    .debugEnable(debugEnable), .traceEnable(traceEnable), .bootRefused(bootRefused),
    .massEraseActive(massEraseActive)
);
`default_nettype wire

// file: testbench/frp_master_model.sv
// bus master model standing for the core and the debug port
// assumes the bench calls access with no overlap, all on clk
`timescale 1ns/100ps
`default_nettype none
module frp_master_model (
    // clock
    input wire logic clk,
    // access request
    output logic accValid,
    output logic accDebug,
    output logic accWrite,
    output logic [1:0] accTarget,
    // answer
    input wire logic accBusError
);
    // ****
    // one-cycle read access
    // ****
    initial begin
        accValid = 1'b0;
        accDebug = 1'b0;
        accWrite = 1'b0;
        accTarget = 2'h0;
    end
    task automatic access(input logic dbg, input logic [1:0] tgt, output logic err);
        @(posedge clk);
        accValid <= 1'b1;
        accDebug <= dbg;
        accTarget <= tgt;
        @(negedge clk);
        err = accBusError;
        @(posedge clk);
        accValid <= 1'b0;
        // released fields turn over so nothing leans on stale values
        accDebug <= ~dbg;
        accTarget <= ~tgt;
    endtask
endmodule // frp_master_model
`default_nettype wire

// file: testbench/tb_flash_readout_write_protection.sv
// bench of the protection block: register tasks and access sequences
// assumes package, header, master model and checker compiled first
`timescale 1ns/100ps
`default_nettype none
`include "frp_consts.svh"
module tb_flash_readout_write_protection;
    logic clk, rst, regWr, regRd, optReload, dualBankSelect, accValid, accDebug, accWrite;
    logic accBusError, flashOpValid, flashOpMass, flashOpBank, flashOpReject;
    logic sramWrValid, sramWrReject, debugEnable, traceEnable, bootRefused, massEraseActive, irq;
    logic [7:0] regAddr, optLevelByte;
    logic [31:0] regWdata, regRdata;
    logic [1:0] bootMode, accTarget, readoutProtectionLevel;
    logic [19:0] flashOpAddr;
    logic [14:0] sramWrAddr;
    int nFail, cmpCount, cyc;
    frp_protect #(.ERASE_CYCLES(4)) i_frp_protect (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .optLevelByte(optLevelByte),
        .optReload(optReload), .bootMode(bootMode), .dualBankSelect(dualBankSelect),
        .accValid(accValid), .accDebug(accDebug), .accWrite(accWrite), .accTarget(accTarget),
        .accBusError(accBusError), .flashOpValid(flashOpValid), .flashOpMass(flashOpMass),
        .flashOpBank(flashOpBank), .flashOpAddr(flashOpAddr), .flashOpReject(flashOpReject),
        .sramWrValid(sramWrValid), .sramWrAddr(sramWrAddr), .sramWrReject(sramWrReject),
        .readoutProtectionLevel(readoutProtectionLevel), .debugEnable(debugEnable),
        .traceEnable(traceEnable), .bootRefused(bootRefused),
        .massEraseActive(massEraseActive), .irq(irq)
    );
    frp_master_model i_frp_master_model (
        .clk(clk), .accValid(accValid), .accDebug(accDebug), .accWrite(accWrite),
        .accTarget(accTarget), .accBusError(accBusError)
    );
    // ****
    // tasks
    // ****
    task automatic close_out();
        if (nFail == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmpCount++;
        if (got !== ex) begin
            nFail++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk("regRdata", ex, regRdata);
    endtask
    task automatic fop(input logic m, input logic b, input logic [19:0] ad, input logic ex);
        @(posedge clk);
        flashOpValid <= 1'b1;
        flashOpMass <= m;
        flashOpBank <= b;
        flashOpAddr <= ad;
        @(negedge clk);
        chk("flashOpReject", {31'h0, ex}, {31'h0, flashOpReject});
        @(posedge clk);
        flashOpValid <= 1'b0;
    endtask
    task automatic sram(input logic [14:0] ad, input logic ex);
        @(posedge clk);
        sramWrValid <= 1'b1;
        sramWrAddr <= ad;
        @(negedge clk);
        chk("sramWrReject", {31'h0, ex}, {31'h0, sramWrReject});
        @(posedge clk);
        sramWrValid <= 1'b0;
    endtask
    task automatic acc(input logic dbg, input logic [1:0] tgt, input logic ex);
        logic e;
        i_frp_master_model.access(dbg, tgt, e);
        chk("accBusError", {31'h0, ex}, {31'h0, e});
    endtask
    task automatic reload(input logic [7:0] b);
        @(posedge clk);
        optLevelByte <= b;
        optReload <= 1'b0;
        @(posedge clk);
        optReload <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic lvl(input logic [1:0] ex);
        @(negedge clk);
        chk("level", {30'h0, ex}, {30'h0, readoutProtectionLevel});
    endtask
    task automatic resetDut();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // ****
    // clock, timeout, sequence
    // ****
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // about a hundred cycles are needed; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            nFail++;
            close_out();
        end
    end
    initial begin
        {rst, regWr, regRd, optReload, dualBankSelect, flashOpValid, flashOpMass} = 7'h40;
        {flashOpBank, sramWrValid, regAddr, regWdata, bootMode} = 44'h0;
        {flashOpAddr, sramWrAddr, optLevelByte} = {35'h0, `FRP_LVL_CODE0};
        resetDut();
        lvl(2'd0);
        acc(1'b1, 2'd0, 1'b0);
        wr(`FRP_ADDR_SRAMWP, 32'h00000005);
        sram(15'h0800, 1'b1);
        sram(15'h0400, 1'b0);
        wr(`FRP_ADDR_SRAMWP, 32'h00000000);
        sram(15'h0800, 1'b1);
        wr(`FRP_ADDR_MASK, 32'h00000001);
        wr(`FRP_ADDR_WRPA, 32'h00020001);
        fop(1'b0, 1'b0, 20'h02000, 1'b1);
        fop(1'b0, 1'b0, 20'h03000, 1'b0);
        fop(1'b1, 1'b0, 20'h00000, 1'b1);
        @(negedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(`FRP_ADDR_STATUS, 32'h00000001);
        chk("irq", 32'h0, {31'h0, irq});
        dualBankSelect <= 1'b1;
        fop(1'b0, 1'b0, 20'h01000, 1'b1);
        fop(1'b0, 1'b0, 20'h01800, 1'b0);
        fop(1'b0, 1'b1, 20'h01000, 1'b0);
        wr(`FRP_ADDR_WRPA, `FRP_RST_WRP);
        reload(8'h00);
        lvl(2'd1);
        for (int t = 0; t < 4; t++) begin
            acc(1'b1, t[1:0], t != 3);
        end
        bootMode <= 2'd2;
        acc(1'b0, 2'd1, 1'b1);
        bootMode <= 2'd0;
        acc(1'b0, 2'd0, 1'b0);
        rd(`FRP_ADDR_STATUS, 32'h00000003);
        wr(`FRP_ADDR_OPTKEY, 32'h000000aa);
        @(negedge clk);
        chk("massEraseActive", 32'h1, {31'h0, massEraseActive});
        repeat (6) @(posedge clk);
        rd(`FRP_ADDR_STATUS, 32'h00000004);
        reload(`FRP_LVL_CODE2);
        lvl(2'd2);
        bootMode <= 2'd1;
        lvl(2'd2);
        chk("bootRefused", 32'h1, {31'h0, bootRefused});
        chk("debugEnable", 32'h0, {31'h0, debugEnable | traceEnable});
        bootMode <= 2'd0;
        wr(`FRP_ADDR_OPTKEY, 32'h000000aa);
        wr(`FRP_ADDR_WRPA, 32'h00010001);
        rd(`FRP_ADDR_WRPA, `FRP_RST_WRP);
        rd(`FRP_ADDR_STATUS, 32'h00000008);
        acc(1'b0, 2'd0, 1'b0);
        acc(1'b1, 2'd3, 1'b1);
        reload(`FRP_LVL_CODE0);
        lvl(2'd2);
        optLevelByte <= `FRP_LVL_CODE2;
        resetDut();
        lvl(2'd2);
        rd(`FRP_ADDR_SRAMWP, 32'h00000000);
        rd(8'h40, 32'h00000000);
        close_out();
    end
endmodule // tb_flash_readout_write_protection
`default_nettype wire
